// [hdl/wdt_pkg.sv]
/*
 * Constants for the watchdog timeout and reset block.
 * Assumes a single system clock; used by every watchdog design file.
 */
package wdt_pkg;

    // Timeout select encodings and the matching power-of-two exponents.
    localparam logic [1:0] SEL_2P15 = 2'h0;
    localparam logic [1:0] SEL_2P18 = 2'h1;
    localparam logic [1:0] SEL_2P21 = 2'h2;
    localparam logic [1:0] SEL_2P24 = 2'h3;
    localparam int EXP_2P15 = 15;
    localparam int EXP_2P18 = 18;
    localparam int EXP_2P21 = 21;
    localparam int EXP_2P24 = 24;

    localparam int CNT_W = 25;
    localparam logic [CNT_W-1:0] CNT_RESET = 25'h0000000;

    // Reset window after the interrupt timeout, in system clocks.
    localparam int RESET_WINDOW_CYCLES = 512;

    // Length of the system reset pulse, in clocks.
    localparam int RST_PULSE_CYCLES = 4;
    localparam logic [2:0] PULSE_RESET = 3'h0;

    typedef enum logic [1:0] {
        WDT_COUNT = 2'b00,
        WDT_WINDOW = 2'b01,
        WDT_FIRE = 2'b11,
        WDT_RELEASE = 2'b10
    } wdt_state_t;

endpackage

// [hdl/wdt_limit.sv]
/*
 * Terminal count decoder for the watchdog interval.
 * Assumes the select input is a registered, stable value.
 */
`timescale 1ns/100ps
module wdt_limit
    import wdt_pkg::*;
(
    // Selection.
    input wire logic [1:0] timeoutSelect,
    // Terminal counts.
    output logic [CNT_W-1:0] intLimit,
    output logic [CNT_W-1:0] rstLimit
);

    function automatic logic [CNT_W-1:0] interval(input logic [1:0] sel);
        case (sel)
            SEL_2P15: interval = CNT_W'(1) << EXP_2P15;
            SEL_2P18: interval = CNT_W'(1) << EXP_2P18;
            SEL_2P21: interval = CNT_W'(1) << EXP_2P21;
            default: interval = CNT_W'(1) << EXP_2P24;
        endcase
    endfunction

    always_comb begin
        intLimit = interval(timeoutSelect) - CNT_W'(1);
        rstLimit = interval(timeoutSelect) + CNT_W'(RESET_WINDOW_CYCLES) - CNT_W'(1);
    end

endmodule // wdt_limit

// [hdl/wdt_timeout_reset.sv]
/*
 * Watchdog timer: free-running counter restarted by software, optional
 * interrupt at the selected timeout, system reset 512 clocks later.
 * Assumes restart, select and enable come from logic on mclk.
 */
// Behaviour
// - Software restart returns counter to start.
// - Select picks 2^15, 2^18, 2^21, 2^24 clocks.
// - Interrupt at timeout only when enabled.
// - Reset follows interrupt timeout by 512 clocks.
// - No restart in window causes system reset.
// - Missed restart resets only when resetEnable is set; interrupt optional.
`timescale 1ns/100ps
module wdt_timeout_reset
    import wdt_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic resetn,
    // Software control.
    input wire logic restart,
    input wire logic [1:0] timeoutSelect,
    input wire logic intEnable,
    input wire logic resetEnable,
    // Events.
    output logic wdtInt,
    output logic sysReset,
    output logic timeoutFlag
);

    wdt_state_t state_q, state_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [2:0] pulse_q, pulse_d;
    logic wdtInt_q, wdtInt_d;
    logic sysReset_q, sysReset_d;
    logic flag_q, flag_d;
    logic [CNT_W-1:0] intLimit;
    logic [CNT_W-1:0] rstLimit;
    logic intHit;
    logic rstHit;
    logic pulseLast;

    wdt_limit limitDec (
        .timeoutSelect(timeoutSelect),
        .intLimit(intLimit),
        .rstLimit(rstLimit)
    );

    // A limit counts as reached once the count is at or past it, so that a
    // shorter interval selected late still ends in a timeout.
    function automatic logic reached(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] lim
    );
        reached = cnt >= lim;
    endfunction

    always_comb begin
        intHit = reached(count_q, intLimit);
        rstHit = reached(count_q, rstLimit);
        pulseLast = pulse_q == 3'(RST_PULSE_CYCLES - 2);
    end

    // Sequencer: counting, reset window, reset pulse, release.
    always_comb begin
        state_d = state_q;
        case (state_q)
            WDT_COUNT: begin
                if (!restart && intHit) begin
                    state_d = WDT_WINDOW;
                end
            end
            WDT_WINDOW: begin
                if (restart) begin
                    state_d = WDT_COUNT;
                end else if (rstHit) begin
                    // A disabled reset still leaves the timeout flag standing.
                    if (resetEnable) begin
                        state_d = WDT_FIRE;
                    end else begin
                        state_d = WDT_COUNT;
                    end
                end
            end
            WDT_FIRE: begin
                if (pulseLast) begin
                    state_d = WDT_RELEASE;
                end
            end
            WDT_RELEASE: begin
                state_d = WDT_COUNT;
            end
            default: begin
                state_d = WDT_COUNT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= WDT_COUNT;
        end else begin
            state_q <= state_d;
        end
    end

    // Interval counter; a restart is ignored while the reset pulse runs.
    always_comb begin
        count_d = count_q + CNT_W'(1);
        case (state_q)
            WDT_COUNT: begin
                if (restart) begin
                    count_d = CNT_RESET;
                end
            end
            WDT_WINDOW: begin
                if (restart) begin
                    count_d = CNT_RESET;
                end else if (rstHit) begin
                    count_d = CNT_RESET;
                end
            end
            default: begin
                count_d = CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_q <= CNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Reset pulse length counter, idle at zero outside the pulse.
    always_comb begin
        pulse_d = PULSE_RESET;
        if (state_q == WDT_FIRE) begin
            pulse_d = pulse_q + 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= PULSE_RESET;
        end else begin
            pulse_q <= pulse_d;
        end
    end

    // Interrupt pulse, one cycle long at the interval timeout.
    always_comb begin
        wdtInt_d = 1'b0;
        if (state_q == WDT_COUNT && !restart && intHit) begin
            wdtInt_d = intEnable;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wdtInt_q <= 1'b0;
        end else begin
            wdtInt_q <= wdtInt_d;
        end
    end

    // System reset, raised at the reset timeout and held through the pulse.
    always_comb begin
        sysReset_d = 1'b0;
        case (state_q)
            WDT_WINDOW: begin
                sysReset_d = !restart && rstHit && resetEnable;
            end
            WDT_FIRE: begin
                sysReset_d = 1'b1;
            end
            default: begin
                sysReset_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sysReset_q <= 1'b0;
        end else begin
            sysReset_q <= sysReset_d;
        end
    end

    // Timeout flag, cleared by any accepted restart or by the end of the pulse.
    always_comb begin
        flag_d = flag_q;
        case (state_q)
            WDT_COUNT: begin
                if (restart) begin
                    flag_d = 1'b0;
                end else if (intHit) begin
                    flag_d = 1'b1;
                end
            end
            WDT_WINDOW: begin
                if (restart) begin
                    flag_d = 1'b0;
                end
            end
            WDT_RELEASE: begin
                flag_d = 1'b0;
            end
            default: begin
                flag_d = flag_q;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign wdtInt = wdtInt_q;
    assign sysReset = sysReset_q;
    assign timeoutFlag = flag_q;

endmodule // wdt_timeout_reset

// [testbench/wdt_checker_asserts.sv]
/* Checker for the watchdog block ports.
   Assumes one clock, mclk, and the active-low reset resetn. */
`timescale 1ns/100ps
module wdt_checker_asserts (
    // Inputs.
    input wire logic mclk,
    input wire logic resetn,
    input wire logic restart,
    input wire logic [1:0] timeoutSelect,
    input wire logic intEnable,
    input wire logic resetEnable,
    // Outputs.
    input wire logic wdtInt,
    input wire logic sysReset,
    input wire logic timeoutFlag
);
    logic [25:0] quiet_q, quiet_d;
    logic [9:0] flag_q, flag_d;
    always_comb begin
        quiet_d = (restart || sysReset) ? 26'h0 : quiet_q + 26'h1;
        flag_d = timeoutFlag ? flag_q + 10'h1 : 10'h0;
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            quiet_q <= 26'h0;
            flag_q <= 10'h0;
        end else begin
            quiet_q <= quiet_d;
            flag_q <= flag_d;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_interval_len: assert property ($rose(timeoutFlag)
        |-> quiet_q == (26'h8000 << (3 * timeoutSelect))) else $error("interval length");
    a_int_enable: assert property ($rose(timeoutFlag) |-> wdtInt == $past(intEnable))
        else $error("interrupt enable");
    a_int_single: assert property (wdtInt |=> !wdtInt) else $error("interrupt width");
    a_rst_delay: assert property ($rose(sysReset) |-> flag_q == 10'h200)
        else $error("reset delay");
    a_rst_fire: assert property (timeoutFlag && flag_q == 10'h1FF && resetEnable && !restart
        |=> sysReset) else $error("reset missing");
    a_rst_pulse: assert property ($rose(sysReset) |-> sysReset[*4] ##1 !sysReset)
        else $error("reset pulse");
    a_restart_clear: assert property (restart && !sysReset |=> !timeoutFlag[*8])
        else $error("restart");
    a_window_cancel: assert property (restart && timeoutFlag && !sysReset
        |=> !sysReset[*5]) else $error("cancel");
    cover property ($rose(sysReset));
    cover property ($rose(wdtInt));
    cover property (restart && timeoutFlag);
    cover property (timeoutFlag && !resetEnable);
endmodule // wdt_checker_asserts
bind wdt_timeout_reset wdt_checker_asserts wdt_checker_asserts_i (.mclk, .resetn, .restart,
    .timeoutSelect, .intEnable, .resetEnable, .wdtInt, .sysReset, .timeoutFlag);

// [testbench/test_wdt_timeout_reset.sv]
/* Testbench for the watchdog: random restarts, timeout, reset, cancel.
   Assumes the checker file is compiled alongside. */
`timescale 1ns/100ps
module test_wdt_timeout_reset import wdt_pkg::*;;
    logic mclk = 0, resetn = 0, restart = 0, intEnable = 0, resetEnable = 1;
    logic [1:0] timeoutSelect = 2'h0;
    logic wdtInt, sysReset, timeoutFlag;
    int num_errors = 0, checks = 0, seed = 74839, n;
    always #50 mclk = ~mclk;
    wdt_timeout_reset wdt_timeout_reset_i (.mclk, .resetn, .restart, .timeoutSelect,
        .intEnable, .resetEnable, .wdtInt, .sysReset, .timeoutFlag);
    function automatic int expWin(input logic c);
        return c ? 600 : RESET_WINDOW_CYCLES;
    endfunction
    task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            num_errors++;
            $display("wrong value %s exp %0h got %0h", what, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task run(input logic en, input logic cancel, input logic ren);
        @(posedge mclk);
        restart <= 1'b1;
        intEnable <= en;
        resetEnable <= ren;
        timeoutSelect <= 2'h0;
        @(posedge mclk);
        restart <= 1'b0;
        n = 0;
        while (timeoutFlag !== 1'b1 && n < 40000) begin
            @(negedge mclk);
            n++;
        end
        cmp("interval", (1 << EXP_2P15) + 1, n);
        cmp("int", en, wdtInt);
        n = 0;
        while (sysReset !== 1'b1 && n < 600) begin
            @(posedge mclk);
            restart <= cancel && n == 300;
            @(negedge mclk);
            n++;
        end
        cmp("window", expWin(cancel || !ren), n);
        repeat (RST_PULSE_CYCLES) @(negedge mclk);
        cmp("after", {1'b0, !ren && !cancel}, {sysReset, timeoutFlag});
        @(posedge mclk);
        restart <= 1'b1;
        @(posedge mclk);
        restart <= 1'b0;
        @(negedge mclk);
        cmp("cleared", 0, timeoutFlag);
        $display("run done");
    endtask
    initial begin
        #11000000;
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        // Frequent restarts keep the count far from its limit.
        repeat (500) begin
            @(posedge mclk);
            restart <= ($random(seed) % 16) == 0;
            timeoutSelect <= 2'($random(seed));
            @(negedge mclk);
            cmp("early flag", 0, timeoutFlag);
        end
        $display("restart test done");
        run(1'b0, 1'b0, 1'b1);
        run(1'b1, 1'b1, 1'b1);
        run(1'b1, 1'b0, 1'b0);
        wrap_up;
    end
endmodule // test_wdt_timeout_reset
